// ==== src/uart_defs.vh ====
// register offsets, field positions and reset values of the serial unit
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef UART_DEFS_VH
`define UART_DEFS_VH
// byte offsets
`define OFS_MODE 8'h00
`define OFS_CTRL0 8'h04
`define OFS_CTRL1 8'h08
`define OFS_SPA 8'h0c
`define OFS_SPB 8'h10
`define OFS_SPC 8'h14
`define OFS_SPD 8'h18
`define OFS_BAUD 8'h1c
`define OFS_TXBUF 8'h20
`define OFS_RXBUF 8'h24
`define OFS_SHARED 8'h28
`define OFS_PINSEL 8'h2c
// serial_mode_reg fields
`define MODE_SMD_HI 2
`define MODE_CLOCK_SOURCE_SEL 3
`define MODE_STOP_LENGTH_SEL 4
`define MODE_PRY 5
`define MODE_PRYE 6
`define MODE_PIN_POLARITY_INVERT 7
// serial_mode_field codes
`define SMD_7BIT 3'h4
`define SMD_8BIT 3'h5
`define SMD_9BIT 3'h6
// transfer_control0 fields
`define C0_CLK_HI 1
`define C0_RTS_SEL 2
`define C0_TX_SHIFT_EMPTY 3
`define C0_CRD 4
`define C0_NCH 5
`define C0_CLOCK_POLARITY_SEL 6
`define C0_BIT_ORDER_SEL 7
// count source codes
`define CS_F1 2'h0
`define CS_F8 2'h1
`define CS_F2N 2'h2
// transfer_control1 fields
`define C1_TE 0
`define C1_TI 1
`define C1_RE 2
`define C1_RI 3
`define C1_IRS 4
`define C1_RRM 5
`define C1_LCH 6
// rx_buffer flag positions
`define RB_OER 12
`define RB_FER 13
`define RB_PER 14
`define RB_SUM 15
// reset values
`define RST_REG8 8'h00
`define RST_BAUD 8'h00
// oversampling
`define OVERSAMPLE 16
`define MID_TICK 4'h7
`define LAST_TICK 4'hf
`define F8_LAST 3'h7
`endif

// ==== src/async_uart.v ====
// asynchronous serial transceiver with apb register access
// assumes pins synchronous to pclk and a single 100 MHz clock domain
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "uart_defs.vh"
module async_uart #(
   parameter F2N_DIV = 16,
   parameter ADDR_W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire serial_clock_pin,
   input wire rx_in,
   output wire tx_out,
   output wire tx_oe,
   input wire flow_in,
   output wire flow_out,
   output wire flow_oe,
   output reg tx_irq,
   output reg rx_irq
);
   reg [7:0] mode_q, c0_q, c1_q, spa_q, spb_q, spc_q, spd_q, baud_q;
   reg [7:0] shared_q, pinsel_q;
   reg [8:0] txbuf_q, rxbuf_q;
   reg tbe_q, rxc_q, oer_q, fer_q, per_q, tx_busy_q;
   reg [7:0] ofs;
   wire [2:0] smd = mode_q[`MODE_SMD_HI:0];
   wire mode_ok = (smd == `SMD_7BIT) | (smd == `SMD_8BIT) |
      (smd == `SMD_9BIT);
   wire [3:0] nd = (smd == `SMD_7BIT) ? 4'd7 :
      (smd == `SMD_8BIT) ? 4'd8 : 4'd9;
   wire pen = mode_q[`MODE_PRYE];
   wire peven = mode_q[`MODE_PRY];
   wire two_stop = mode_q[`MODE_STOP_LENGTH_SEL];
   wire pin_polarity_invert = mode_q[`MODE_PIN_POLARITY_INVERT];
   wire lch = c1_q[`C1_LCH];
   // msb first honoured only for 8-bit characters
   wire msb_first = c0_q[`C0_BIT_ORDER_SEL] & (smd == `SMD_8BIT);
   wire cts_en = ~c0_q[`C0_CRD] & ~c0_q[`C0_RTS_SEL];
   wire rts_en = ~c0_q[`C0_CRD] & c0_q[`C0_RTS_SEL];

   // apb decode; loads colliding with buffer access stall one cycle
   wire acc = psel & penable;
   wire wr_acc = acc & pwrite;
   wire rd_acc = acc & ~pwrite;
   reg tx_load, rx_xfer;
   wire hit_tx = (ofs == `OFS_TXBUF);
   wire hit_rx = (ofs == `OFS_RXBUF);
   wire stall = (wr_acc & hit_tx & tx_load) | (rd_acc & hit_rx & rx_xfer);
   reg mapped;
   assign pready = ~stall;
   assign pslverr = acc & ~mapped;
   wire wr_go = wr_acc & pready & mapped;
   wire rd_go = rd_acc & pready & mapped;

   // read mux over register flops
   always @* begin
      ofs = {paddr[7:2], 2'b00};
      mapped = (paddr[1:0] == 2'b00) & (ofs <= `OFS_PINSEL);
      prdata = 32'h0000_0000;
      case (ofs)
         `OFS_MODE: prdata[7:0] = mode_q;
         `OFS_CTRL0: begin
            prdata[7:0] = c0_q;
            prdata[`C0_TX_SHIFT_EMPTY] = ~tx_busy_q;
         end
         `OFS_CTRL1: begin
            prdata[7:0] = c1_q;
            prdata[`C1_TI] = tbe_q;
            prdata[`C1_RI] = rxc_q;
         end
         `OFS_SPA: prdata[7:0] = spa_q;
         `OFS_SPB: prdata[7:0] = spb_q;
         `OFS_SPC: prdata[7:0] = spc_q;
         `OFS_SPD: prdata[7:0] = spd_q;
         `OFS_BAUD: prdata[7:0] = baud_q;
         `OFS_RXBUF: begin
            prdata[8:0] = rxbuf_q;
            prdata[`RB_OER] = oer_q;
            prdata[`RB_FER] = fer_q;
            prdata[`RB_PER] = per_q;
            prdata[`RB_SUM] = oer_q | fer_q | per_q;
         end
         `OFS_SHARED: prdata[7:0] = shared_q;
         `OFS_PINSEL: prdata[7:0] = pinsel_q;
         default: prdata = 32'h0000_0000;
      endcase
   end

   // plain configuration registers; status bits are held elsewhere
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= `RST_REG8;
         c0_q <= `RST_REG8;
         c1_q <= `RST_REG8;
         spa_q <= `RST_REG8;
         spb_q <= `RST_REG8;
         spc_q <= `RST_REG8;
         spd_q <= `RST_REG8;
         baud_q <= `RST_BAUD;
         shared_q <= `RST_REG8;
         pinsel_q <= `RST_REG8;
      end else if (wr_go) begin
         case (ofs)
            `OFS_MODE: mode_q <= pwdata[7:0];
            `OFS_CTRL0: c0_q <= pwdata[7:0];
            `OFS_CTRL1: c1_q <= pwdata[7:0];
            `OFS_SPA: spa_q <= pwdata[7:0];
            `OFS_SPB: spb_q <= pwdata[7:0];
            `OFS_SPC: spc_q <= pwdata[7:0];
            `OFS_SPD: spd_q <= pwdata[7:0];
            `OFS_BAUD: baud_q <= pwdata[7:0];
            `OFS_SHARED: shared_q <= pwdata[7:0];
            `OFS_PINSEL: pinsel_q <= pwdata[7:0];
            default: mode_q <= mode_q;
         endcase
      end
   end

   // count source prescaler and external clock edge detect
   reg [2:0] f8_q;
   reg [15:0] f2n_q;
   reg sclk_q;
   reg cs_tick;
   wire sclk_rise = serial_clock_pin & ~sclk_q;
   wire sclk_fall = ~serial_clock_pin & sclk_q;
   always @* begin
      if (mode_q[`MODE_CLOCK_SOURCE_SEL]) begin
         cs_tick = sclk_rise;
      end else begin
         case (c0_q[`C0_CLK_HI:0])
            `CS_F1: cs_tick = 1'b1;
            `CS_F8: cs_tick = (f8_q == `F8_LAST);
            `CS_F2N: cs_tick = (f2n_q == F2N_DIV - 1);
            default: cs_tick = 1'b1;
         endcase
      end
   end

   // divide by m+1 into the 16x tick; free running keeps phase simple
   reg [7:0] brg_q;
   wire tick16 = cs_tick & (brg_q == 8'h00);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f8_q <= 3'h0;
         f2n_q <= 16'h0000;
         sclk_q <= 1'b1; // pin idles high, so no false edge
         brg_q <= 8'h00;
      end else begin
         f8_q <= f8_q + 3'h1;
         f2n_q <= (f2n_q == F2N_DIV - 1) ? 16'h0000 : f2n_q + 16'h0001;
         sclk_q <= serial_clock_pin;
         if (cs_tick)
            brg_q <= (brg_q == 8'h00) ? baud_q : brg_q - 8'h01;
      end
   end

   // transmit frame assembly: start, data, parity, stops (ones fill)
   reg [12:0] frame;
   reg [8:0] txd;
   reg txpar;
   integer i;
   integer j;
   always @* begin
      txd = txbuf_q;
      if (msb_first)
         for (i = 0; i < 8; i = i + 1)
            txd[i] = txbuf_q[7-i];
      if (lch)
         txd = ~txd;
      frame = 13'h1ffe;
      txpar = ~peven;
      for (i = 0; i < 9; i = i + 1) begin
         if (i < nd) begin
            frame[i+1] = txd[i];
            txpar = txpar ^ txd[i];
         end
      end
      if (pen)
         frame[nd+1] = txpar;
   end

   reg [12:0] tx_sh_q;
   reg [3:0] tx_bits_q, tx_sub_q;
   reg tx_line_q;
   wire cts_ok = ~cts_en | ~flow_in;
   always @* begin
      tx_load = c1_q[`C1_TE] & ~tbe_q & cts_ok & ~tx_busy_q & mode_ok;
   end
   wire tx_bit_end = tx_busy_q & tick16 & (tx_sub_q == `LAST_TICK);
   wire tx_done = tx_bit_end & (tx_bits_q == 4'h1);

   // transmit shifter; cts is looked at only between characters
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_sh_q <= 13'h1fff;
         tx_bits_q <= 4'h0;
         tx_sub_q <= 4'h0;
         tx_busy_q <= 1'b0;
         tx_line_q <= 1'b1;
         tbe_q <= 1'b1;
         txbuf_q <= 9'h000;
         tx_irq <= 1'b0;
      end else begin
         tx_irq <= c1_q[`C1_IRS] ? tx_done : tx_load;
         if (wr_go & hit_tx) begin
            txbuf_q <= pwdata[8:0];
            tbe_q <= 1'b0;
         end else if (tx_load) begin
            tbe_q <= 1'b1;
         end
         if (tx_load) begin
            tx_sh_q <= frame;
            tx_bits_q <= 4'd1 + nd + {3'b000, pen} + {3'b000, two_stop} +
               4'd1;
            tx_sub_q <= 4'h0;
            tx_busy_q <= 1'b1;
            tx_line_q <= 1'b1;
         end else if (tx_busy_q) begin
            tx_line_q <= tx_sh_q[0];
            if (tick16)
               tx_sub_q <= tx_sub_q + 4'h1;
            if (tx_bit_end) begin
               tx_sh_q <= {1'b1, tx_sh_q[12:1]};
               tx_bits_q <= tx_bits_q - 4'h1;
               if (tx_bits_q == 4'h1)
                  tx_busy_q <= 1'b0;
            end
         end else begin
            tx_line_q <= 1'b1;
         end
      end
   end

   // pin drive; open drain only pulls low and floats for a high
   wire tx_level = tx_line_q ^ pin_polarity_invert;
   assign tx_out = c0_q[`C0_NCH] ? 1'b0 : tx_level;
   assign tx_oe = mode_ok & (~c0_q[`C0_NCH] | ~tx_level);

   // receiver
   reg rx_prev_q, rx_busy_q, rx_ovr_q;
   reg [3:0] rx_sub_q, rx_idx_q;
   reg [12:0] rx_bits_q;
   wire rx_lvl = rx_in ^ pin_polarity_invert;
   wire [3:0] rx_last = nd + {3'b000, pen} + {3'b000, two_stop} + 4'd1;
   wire [3:0] ovr_idx = two_stop ? nd + {3'b000, pen} + 4'd1 :
      nd + {3'b000, pen};
   wire rx_start = c1_q[`C1_RE] & mode_ok & ~rx_busy_q & rx_prev_q &
      ~rx_lvl;
   wire rx_samp = rx_busy_q & tick16 & (rx_sub_q == `MID_TICK);
   reg [8:0] rxd;
   reg rxpar, stop_ok;
   always @* begin
      rxd = 9'h000;
      rxpar = peven; // ends at 1 when the ones count matches the setting
      for (j = 0; j < 9; j = j + 1) begin
         if (j < nd) begin
            rxd[j] = rx_bits_q[j+1];
            rxpar = rxpar ^ rx_bits_q[j+1];
         end
      end
      if (pen)
         rxpar = rxpar ^ rx_bits_q[nd+1];
      stop_ok = rx_lvl & (~two_stop | rx_bits_q[rx_last-4'd1]);
      if (msb_first)
         for (j = 0; j < 8; j = j + 1)
            rxd[j] = rx_bits_q[8-j];
      if (lch)
         rxd = ~rxd;
      // bits above the character length read zero even when inverted
      for (j = 0; j < 9; j = j + 1)
         if (j >= nd)
            rxd[j] = 1'b0;
      rx_xfer = c1_q[`C1_RE] & rx_samp & (rx_idx_q == rx_last) &
         ~rx_ovr_q & ~(rxc_q & ovr_idx == rx_last);
   end

   // bit timing restarts at each start edge; bits land by index
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_prev_q <= 1'b1;
         rx_busy_q <= 1'b0;
         rx_ovr_q <= 1'b0;
         rx_sub_q <= 4'h0;
         rx_idx_q <= 4'h0;
         rx_bits_q <= 13'h0000;
         rxbuf_q <= 9'h000;
         rxc_q <= 1'b0;
         oer_q <= 1'b0;
         fer_q <= 1'b0;
         per_q <= 1'b0;
         rx_irq <= 1'b0;
      end else begin
         rx_prev_q <= rx_lvl;
         rx_irq <= rx_xfer;
         if (rx_xfer) begin
            rxbuf_q <= rxd;
            rxc_q <= 1'b1;
         end else if (rd_go & hit_rx) begin
            rxc_q <= 1'b0;
         end
         if (!c1_q[`C1_RE]) begin
            rx_busy_q <= 1'b0;
            rxc_q <= 1'b0;
            oer_q <= 1'b0;
            fer_q <= 1'b0;
            per_q <= 1'b0;
         end else if (rx_start) begin
            rx_busy_q <= 1'b1;
            rx_sub_q <= 4'h0;
            rx_idx_q <= 4'h0;
            rx_ovr_q <= 1'b0;
         end else if (rx_busy_q) begin
            if (tick16)
               rx_sub_q <= rx_sub_q + 4'h1;
            if (rx_samp) begin
               rx_bits_q[rx_idx_q] <= rx_lvl;
               rx_idx_q <= rx_idx_q + 4'h1;
               if (rx_idx_q == 4'h0 && rx_lvl)
                  rx_busy_q <= 1'b0;
               if (rx_idx_q == ovr_idx && rxc_q) begin
                  oer_q <= 1'b1;
                  rx_ovr_q <= 1'b1;
               end
               if (rx_idx_q == rx_last) begin
                  rx_busy_q <= 1'b0;
                  if (!stop_ok)
                     fer_q <= 1'b1;
                  if (pen && !rxpar)
                     per_q <= 1'b1;
               end
            end
         end
      end
   end

   // rts: low while ready, forced high by a clock pin fall or a start
   reg rts_q;
   wire rx_ready = c1_q[`C1_RE] & ~rxc_q & ~rx_busy_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         rts_q <= 1'b1;
      else if (sclk_fall | rx_start | ~rx_ready)
         rts_q <= 1'b1;
      else
         rts_q <= 1'b0;
   end
   assign flow_out = rts_q;
   assign flow_oe = rts_en;
endmodule

// ==== dv/async_uart_sva.sv ====
// assertion checker on the serial unit's top-level ports
// assumes count source f1 and normal pin polarity during traffic
`timescale 1ns/1ps
`include "uart_defs.vh"
module async_uart_sva #(
   parameter F2N_DIV = 16,
   parameter ADDR_W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire serial_clock_pin,
   input wire rx_in,
   input wire tx_out,
   input wire tx_oe,
   input wire flow_in,
   input wire flow_out,
   input wire flow_oe,
   input wire tx_irq,
   input wire rx_irq
);
   reg [7:0] mode_q;
   reg [7:0] ctrl0_q;
   reg [7:0] ctrl1_q;
   reg [7:0] baud_q;
   reg [12:0] low_q;
   wire wr_ok;
   wire [12:0] bit_len;
   assign wr_ok = psel && penable && pready && pwrite && !pslverr;
   assign bit_len = {1'b0, baud_q, 4'h0} + 13'h0010;
   // shadow copies of control bytes, since only the bus is visible here
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= 8'h00;
         ctrl0_q <= 8'h00;
         ctrl1_q <= 8'h00;
         baud_q <= 8'h00;
      end else if (wr_ok) begin
         if (paddr == `OFS_MODE) mode_q <= pwdata[7:0];
         if (paddr == `OFS_CTRL0) ctrl0_q <= pwdata[7:0];
         if (paddr == `OFS_CTRL1) ctrl1_q <= pwdata[7:0];
         if (paddr == `OFS_BAUD) baud_q <= pwdata[7:0];
      end
   end
   // low run length; wraps for huge divisors or tx_out held low by open drain or inversion, which we avoid
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) low_q <= 13'h0000;
      else low_q <= tx_out ? 13'h0000 : low_q + 13'h0001;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_rb_read;
      psel && penable && pready && !pwrite && paddr == `OFS_RXBUF;
   endsequence
   sequence s_tx_load;
      tx_irq && !ctrl1_q[`C1_IRS];
   endsequence
   AST_TX_PULSE: assert property (tx_irq |=> !tx_irq)
      else $error("tx interrupt wider than one cycle");
   AST_RX_PULSE: assert property (rx_irq |=> !rx_irq)
      else $error("rx interrupt wider than one cycle");
   AST_BIT_TIME: assert property ($rose(tx_out) |->
      low_q != 13'h0000 && low_q % bit_len == 13'h0000)
      else $error("low run not a whole number of bits");
   AST_CTS_HOLD: assert property (s_tx_load ##0
      (!ctrl0_q[`C0_CRD] && !ctrl0_q[`C0_RTS_SEL]) |->
      !$past(flow_in) || !$past(flow_in, 2) || !$past(flow_in, 3))
      else $error("character loaded while clear to send was high");
   AST_SUM: assert property (s_rb_read |->
      prdata[`RB_SUM] == (|prdata[14:12]))
      else $error("sum flag differs from error flags");
   AST_WIDTH8: assert property (s_rb_read ##0
      (mode_q[2:0] == `SMD_8BIT) |-> prdata[11:8] == 4'h0)
      else $error("8-bit character shows bits above 7");
   AST_RX_OFF: assert property (!ctrl1_q[`C1_RE] &&
      !$past(ctrl1_q[`C1_RE]) |-> !rx_irq)
      else $error("rx interrupt while reception disabled");
   AST_TX_DRIVE: assert property (mode_q[2] && $past(mode_q[2]) &&
      !ctrl0_q[`C0_NCH] |-> tx_oe)
      else $error("transmit pin not driven in serial mode");
endmodule
bind async_uart async_uart_sva #(.F2N_DIV(F2N_DIV), .ADDR_W(ADDR_W))
   i_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serial_clock_pin(serial_clock_pin),
   .rx_in(rx_in), .tx_out(tx_out), .tx_oe(tx_oe), .flow_in(flow_in),
   .flow_out(flow_out), .flow_oe(flow_oe), .tx_irq(tx_irq), .rx_irq(rx_irq));

// ==== dv/serial_peer.sv ====
// far-end serial device: sends frames and captures the block's frames
// assumes the bench sets character format before any traffic
`timescale 1ns/1ps
module serial_peer #(
   parameter BIT = 16
) (
   input wire clk,
   input wire line_in,
   output reg line_out,
   output reg cts_n
);
   int nbits = 8;
   bit par_en = 1'b0;
   bit two_stop = 1'b0;
   logic [8:0] got_d;
   logic got_p;
   logic got_stop;
   int got_n = 0;
   initial begin
      line_out = 1'b1;
      cts_n = 1'b0;
   end
   // one bit time, changed just after a clock edge
   task automatic drive(input logic b);
      line_out <= b;
      repeat (BIT) @(posedge clk);
   endtask
   // whole frame; the stop bit is broken only on command
   task automatic send(input logic [8:0] d, input logic p, input bit bad);
      drive(1'b0);
      for (int i = 0; i < nbits; i++) drive(d[i]);
      if (par_en) drive(p);
      drive(!bad);
      if (two_stop) drive(1'b1);
      drive(1'b1);
   endtask
   // capture at mid-bit so edge placement never matters
   always @(negedge line_in) begin
      got_d = 9'h000;
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < nbits; i++) begin
         repeat (BIT) @(posedge clk);
         got_d[i] = line_in;
      end
      if (par_en) begin
         repeat (BIT) @(posedge clk);
         got_p = line_in;
      end
      repeat (BIT) @(posedge clk);
      got_stop = line_in;
      got_n++;
   end
endmodule

// ==== dv/async_serial_uart_mode_bench.sv ====
// self-checking bench: apb master, random characters both ways
// assumes divisor 0 with source f1, so one bit is 16 clocks
`timescale 1ns/1ps
`include "uart_defs.vh"
module async_serial_uart_mode_bench;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg sclk = 1'b0;
   wire flow_out, flow_oe;
   reg psel, penable, pwrite;
   reg [7:0] paddr;
   reg [31:0] pwdata;
   wire [31:0] prdata;
   wire pready, pslverr, tx_out, tx_oe, tx_irq, rx_irq, rx_in, flow_in;
   int err_total = 0;
   int compares = 0;
   int cyc = 0;
   int irqs = 0;
   int seed = 32'h568a1b52;
   int n0;
   logic [31:0] rq;
   logic re;
   logic [8:0] d, msk;
   bit ev;
   logic [7:0] modes [5] = '{8'h04, 8'h06, 8'h15, 8'h45, 8'h65};
   async_uart #(.F2N_DIV(2), .ADDR_W(8)) i_dut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serial_clock_pin(sclk), .rx_in(rx_in),
      .tx_out(tx_out), .tx_oe(tx_oe), .flow_in(flow_in),
      .flow_out(flow_out), .flow_oe(flow_oe), .tx_irq(tx_irq),
      .rx_irq(rx_irq));
   // a released transmit pin reads as its pull-up level
   serial_peer #(.BIT(16)) i_peer (.clk(pclk),
      .line_in(tx_oe ? tx_out : 1'b1),
      .line_out(rx_in), .cts_n(flow_in));
   always #5 pclk = ~pclk;
   // hang guard and receive interrupt tally
   always @(posedge pclk) begin
      cyc++;
      if (rx_irq === 1'b1) irqs++;
      if (cyc == 20000) begin
         err_total++;
         give_verdict;
      end
   end
   task automatic give_verdict;
      if (err_total == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   // one transfer; no cycle count assumed, the guard ends a hang
   task automatic apb(input logic w, input logic [7:0] a, input [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rq = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic par_of(input logic [8:0] v, input int n);
      logic p;
      p = 1'b0;
      for (int i = 0; i < n; i++) p = p ^ v[i];
      return ev ? p : !p;
   endfunction
   // errors are sticky, so each case starts with reception re-enabled
   task automatic err_case(input bit bad_p, bad_s, input [3:0] flags);
      apb(1'b1, `OFS_CTRL1, 32'h1);
      apb(1'b1, `OFS_CTRL1, 32'h5);
      i_peer.send(9'h3c, par_of(9'h3c, 8) ^ bad_p, bad_s);
      apb(1'b0, `OFS_RXBUF, 32'h0);
      chk("error flags", rq[15:12], flags);
   endtask
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `OFS_CTRL1, 32'h0);
      chk("ctrl1 reset", rq, 32'h2);
      apb(1'b0, `OFS_CTRL0, 32'h0);
      chk("ctrl0 reset", rq, 32'h8);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped", re, 1'b1);
      apb(1'b1, `OFS_BAUD, 32'h0);
      foreach (modes[k]) begin
         i_peer.nbits = 7 + modes[k][1:0];
         i_peer.par_en = modes[k][6];
         i_peer.two_stop = modes[k][4];
         ev = modes[k][5];
         msk = 9'h1ff >> (9 - i_peer.nbits);
         apb(1'b1, `OFS_MODE, {24'h0, modes[k]});
         apb(1'b1, `OFS_CTRL1, 32'h5);
         d = 9'($random(seed)) & msk;
         n0 = i_peer.got_n;
         apb(1'b1, `OFS_TXBUF, {23'h0, d});
         wait (i_peer.got_n == n0 + 1);
         chk("tx data", i_peer.got_d, d);
         chk("tx stop", i_peer.got_stop, 1'b1);
         if (i_peer.par_en)
            chk("tx parity", i_peer.got_p, par_of(d, i_peer.nbits));
         d = 9'($random(seed)) & msk;
         i_peer.send(d, par_of(d, i_peer.nbits), 1'b0);
         apb(1'b0, `OFS_RXBUF, 32'h0);
         chk("rx word", rq, {23'h0, d});
      end
      i_peer.cts_n <= 1'b1;
      n0 = i_peer.got_n;
      apb(1'b1, `OFS_TXBUF, 32'h0a5);
      repeat (64) @(posedge pclk);
      apb(1'b0, `OFS_CTRL1, 32'h0);
      chk("held by cts", rq[`C1_TI], 1'b0);
      chk("no frame", i_peer.got_n, n0);
      i_peer.cts_n <= 1'b0;
      wait (i_peer.got_n == n0 + 1);
      chk("released", i_peer.got_d, 9'h0a5);
      err_case(1'b0, 1'b1, 4'ha);
      err_case(1'b1, 1'b0, 4'hc);
      err_case(1'b0, 1'b0, 4'h0);
      // second character arrives with the first still unread
      n0 = irqs;
      i_peer.send(9'h11, par_of(9'h11, 8), 1'b0);
      i_peer.send(9'h22, par_of(9'h22, 8), 1'b0);
      chk("overrun irq", irqs - n0, 1);
      apb(1'b0, `OFS_RXBUF, 32'h0);
      chk("overrun flag", rq[15:12], 4'h9);
      // rts mode: low while ready, high after a clock pin fall
      apb(1'b1, `OFS_CTRL0, 32'h4);
      apb(1'b0, `OFS_CTRL0, 32'h0);
      chk("ctrl0 rts", rq, 32'hc);
      chk("rts ready", {flow_oe, flow_out}, 2'h2);
      sclk <= 1'b1;
      @(posedge pclk);
      sclk <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("rts on clk fall", flow_out, 1'b1);
      // msb first with data inversion, looped back and read as written
      apb(1'b1, `OFS_CTRL0, 32'h80);
      apb(1'b1, `OFS_CTRL1, 32'h51);
      apb(1'b1, `OFS_CTRL1, 32'h55);
      n0 = i_peer.got_n;
      apb(1'b1, `OFS_TXBUF, 32'h001);
      wait (i_peer.got_n == n0 + 1);
      chk("msb inverted", i_peer.got_d, 9'h07f);
      chk("parity plain", i_peer.got_p, par_of(9'h07f, 8));
      i_peer.send(9'h07f, par_of(9'h07f, 8), 1'b0);
      apb(1'b0, `OFS_RXBUF, 32'h0);
      chk("rx msb inverted", rq, 32'h1);
      give_verdict;
   end
endmodule
